/* File: core/motor_pulse_pin_control.sv */
// Purpose: pin-level control of a pulse motor controller
// Assumes: profile engine on sys_clk supplies step ticks; pins are asynchronous
// Notes: registers are reached one byte per access
module motor_pulse_pin_control
  import motor_pin_pkg::*;
(
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire pins_s pins,
  input wire engine_s eng,
  input wire logic [27:0] remain_in,
  input wire logic [12:0] speed_in,
  output logic ext_start_pin_out,
  output logic ext_start_pin_oe_n,
  output logic shared_pin_1,
  output logic shared_pin_2,
  output logic shared_pin_3,
  output logic shared_pin_4,
  output logic clear_reduce_pin,
  output logic gpio_0_out,
  output logic gpio_0_oe_n,
  output logic gpio_1_out,
  output logic gpio_1_oe_n,
  output logic motor_run,
  output logic decel_req,
  output logic speed_two_sel
);

  ////////////////////////////////////////////////////////////////////
  // pin synchronisers
  logic [6:0] sync1_ff;
  logic [6:0] sync2_ff;
  logic [6:0] sync3_ff;
  logic [6:0] lvl_ff;
  pins_s lv;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      sync1_ff <= 7'h7f;
      sync2_ff <= 7'h7f;
      sync3_ff <= 7'h7f;
      lvl_ff <= 7'h7f;
    end else begin
      sync1_ff <= pins;
      sync2_ff <= sync1_ff;
      sync3_ff <= sync2_ff;
      lvl_ff <= (sync2_ff & sync3_ff) | (lvl_ff & (sync2_ff | sync3_ff));
    end
  end

  assign lv = lvl_ff;

  ////////////////////////////////////////////////////////////////////
  // register bytes
  logic [7:0] mem_ff [0:55];
  logic writable;
  logic [31:0] env1;
  logic [15:0] op_mode;
  logic [7:0] gpio_ctl;
  logic cmd_wr;

  assign writable = ((reg_addr >= OFS_ENV2) && (reg_addr <= OFS_COMMAND)) ||
                    ((reg_addr >= OFS_INT_CAUSE) && (reg_addr < OFS_REMAIN));
  assign cmd_wr = reg_wr && (reg_addr == OFS_COMMAND);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      for (int i = 0; i < 56; i++) begin
        mem_ff[i] <= CFG_RESET;
      end
    end else if (reg_wr && writable) begin
      mem_ff[reg_addr[5:0]] <= reg_wdata;
    end
  end

  assign env1 = {mem_ff[8], mem_ff[9], mem_ff[10], mem_ff[11]};
  assign op_mode = {mem_ff[35], mem_ff[36]};
  assign gpio_ctl = mem_ff[45];

  logic stop_pol;
  logic stop_en;
  logic stop_act;
  logic sync_en;
  logic inp_wait;
  logic timer_mode;
  logic halt_on;
  logic inpos_on;
  logic [2:0] fmt;

  assign stop_pol = env1[ENV1_STOP_POL];
  assign stop_act = env1[ENV1_STOP_ACT];
  assign fmt = env1[ENV1_FMT_LSB +: 3];
  assign sync_en = op_mode[MODE_SYNC_EN];
  assign stop_en = op_mode[MODE_STOP_EN];
  assign inp_wait = op_mode[MODE_INP_WAIT];
  assign timer_mode = (op_mode[6:0] == MODE_TIMER);
  assign halt_on = stop_en && (lv.halt == stop_pol);
  assign inpos_on = (lv.inpos_fh == env1[ENV1_INP_POL]);

  ////////////////////////////////////////////////////////////////////
  // start pin filter and one-shot
  logic [2:0] low_cnt_ff;
  logic start_evt;
  logic [3:0] start_pulse_out_cmd_cnt_ff;
  logic start_oe_n_ff;

  assign start_evt = !lv.start_n && (low_cnt_ff == GLITCH_CYCLES - 3'h1);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      low_cnt_ff <= 3'h0;
    end else if (lv.start_n) begin
      low_cnt_ff <= 3'h0;
    end else if (low_cnt_ff < GLITCH_CYCLES) begin
      low_cnt_ff <= low_cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      start_pulse_out_cmd_cnt_ff <= 4'h0;
      start_oe_n_ff <= 1'b1;
    end else if (cmd_wr && (reg_wdata == CMD_START_PULSE_OUT)) begin
      start_pulse_out_cmd_cnt_ff <= START_PULSE_OUT_CMD_CYCLES;
      start_oe_n_ff <= 1'b0;
    end else if (start_pulse_out_cmd_cnt_ff != 4'h0) begin
      start_pulse_out_cmd_cnt_ff <= start_pulse_out_cmd_cnt_ff - 4'h1;
      start_oe_n_ff <= (start_pulse_out_cmd_cnt_ff == 4'h1);
    end
  end

  ////////////////////////////////////////////////////////////////////
  // motion sequencing
  motion_e state_ff;
  logic speed_two_ff;
  logic [3:0] clr_cnt_ff;
  logic moving;

  assign moving = (state_ff == ST_RUN) || (state_ff == ST_DECEL);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_ff <= ST_IDLE;
    end else if (cmd_wr && (reg_wdata == CMD_HALT_NOW)) begin
      state_ff <= ST_IDLE;
    end else if (cmd_wr && (reg_wdata == CMD_START)) begin
      if (halt_on) begin
        state_ff <= ST_IDLE;
      end else if (sync_en) begin
        state_ff <= ST_ARMED;
      end else begin
        state_ff <= ST_RUN;
      end
    end else begin
      unique case (state_ff)
        ST_IDLE: begin
          state_ff <= ST_IDLE;
        end
        ST_ARMED: begin
          if (halt_on) begin
            state_ff <= ST_IDLE;
          end else if (start_evt) begin
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (halt_on) begin
            state_ff <= stop_act ? ST_DECEL : ST_IDLE;
          end else if (eng.pulses_done) begin
            state_ff <= inp_wait ? ST_SETTLE : ST_IDLE;
          end
        end
        ST_DECEL: begin
          if (eng.decel_done) begin
            state_ff <= ST_IDLE;
          end
        end
        ST_SETTLE: begin
          if (inpos_on) begin
            state_ff <= ST_IDLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      speed_two_ff <= 1'b0;
    end else if (cmd_wr && (reg_wdata == CMD_SPEED_TWO)) begin
      speed_two_ff <= 1'b1;
    end else if (cmd_wr && (reg_wdata == CMD_START)) begin
      speed_two_ff <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clr_cnt_ff <= 4'h0;
    end else if (moving && (halt_on && !stop_act || cmd_wr && (reg_wdata == CMD_HALT_NOW))) begin
      clr_cnt_ff <= CLEAR_CYCLES;
    end else if (clr_cnt_ff != 4'h0) begin
      clr_cnt_ff <= clr_cnt_ff - 4'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////
  // excitation sequencer
  logic [2:0] phase_idx_ff;
  logic step_ok;
  logic [3:0] uni;
  logic [3:0] phases;

  assign step_ok = eng.step_tick && moving;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      phase_idx_ff <= 3'h1;
    end else if (step_ok && !timer_mode && lv.drive_type) begin
      if (lv.inpos_fh) begin
        phase_idx_ff <= eng.dir_neg ? phase_idx_ff - 3'h1 : phase_idx_ff + 3'h1;
      end else begin
        phase_idx_ff <= eng.dir_neg ? {phase_idx_ff[2:1] - 2'h1, 1'b1} :
                                      {phase_idx_ff[2:1] + 2'h1, 1'b1};
      end
    end
  end

  always_comb begin
    uni = 4'h0;
    unique case (phase_idx_ff)
      3'h0: uni = 4'h8;
      3'h1: uni = 4'hc;
      3'h2: uni = 4'h4;
      3'h3: uni = 4'h6;
      3'h4: uni = 4'h2;
      3'h5: uni = 4'h3;
      3'h6: uni = 4'h1;
      3'h7: uni = 4'h9;
    endcase
  end

  // bipolar: A polarity, B polarity, A on, B on
  assign phases = lv.scheme ? {uni[3], uni[2], uni[3] | uni[1], uni[2] | uni[0]} : uni;

  ////////////////////////////////////////////////////////////////////
  // output pins
  logic pulse_raw;
  logic dir_raw;
  logic clr_raw;
  logic [3:0] pin_ff;
  logic clr_pin_ff;

  assign pulse_raw = step_ok && !timer_mode;
  assign dir_raw = fmt[2] ? (pulse_raw && eng.dir_neg) : eng.dir_neg;
  assign clr_raw = env1[ENV1_CLR_SEL] ? (state_ff == ST_IDLE) : (clr_cnt_ff != 4'h0);

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pin_ff <= 4'h0;
    end else if (lv.drive_type) begin
      pin_ff <= phases;
    end else begin
      pin_ff[3] <= (fmt[2] ? (pulse_raw && !eng.dir_neg) : pulse_raw) ^ fmt[0];
      pin_ff[2] <= dir_raw ^ fmt[1];
      pin_ff[1:0] <= gpio_ctl[GPIO_GP_LSB +: 2];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      clr_pin_ff <= 1'b1;
    end else begin
      clr_pin_ff <= env1[ENV1_CLR_POL] ? clr_raw : !clr_raw;
    end
  end

  logic [1:0] gp_out_ff;
  logic [1:0] gp_oe_n_ff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      gp_out_ff <= 2'h0;
      gp_oe_n_ff <= 2'h3;
    end else begin
      gp_out_ff <= gpio_ctl[GPIO_OUT_LSB +: 2];
      gp_oe_n_ff <= ~gpio_ctl[GPIO_DIR_LSB +: 2];
    end
  end

  logic start_out_ff;
  logic run_ff;
  logic decel_ff;

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      start_out_ff <= 1'b0;
      run_ff <= 1'b0;
      decel_ff <= 1'b0;
    end else begin
      start_out_ff <= 1'b0;
      run_ff <= moving;
      decel_ff <= (state_ff == ST_DECEL);
    end
  end

  assign ext_start_pin_out = start_out_ff;
  assign ext_start_pin_oe_n = start_oe_n_ff;
  assign shared_pin_1 = pin_ff[3];
  assign shared_pin_2 = pin_ff[2];
  assign shared_pin_3 = pin_ff[1];
  assign shared_pin_4 = pin_ff[0];
  assign clear_reduce_pin = clr_pin_ff;
  assign gpio_0_out = gp_out_ff[0];
  assign gpio_0_oe_n = gp_oe_n_ff[0];
  assign gpio_1_out = gp_out_ff[1];
  assign gpio_1_oe_n = gp_oe_n_ff[1];
  assign motor_run = run_ff;
  assign decel_req = decel_ff;
  assign speed_two_sel = speed_two_ff;

  ////////////////////////////////////////////////////////////////////
  // read path
  logic [31:0] status;
  logic [7:0] rd_nxt;
  logic [7:0] rdata_ff;
  logic [7:0] off;

  function automatic logic [7:0] pick(input logic [31:0] w, input logic [1:0] k);
    logic [7:0] b;
    b = 8'h00;
    unique case (k)
      2'h0: b = w[31:24];
      2'h1: b = w[23:16];
      2'h2: b = w[15:8];
      2'h3: b = w[7:0];
    endcase
    return b;
  endfunction

  assign status = {21'h0, (state_ff == ST_SETTLE), moving, phases, !clr_pin_ff ^ env1[ENV1_CLR_POL],
                   lv.scheme, inpos_on, lv.halt, lv.start_n};

  always_comb begin
    rd_nxt = 8'h00;
    off = 8'h00;
    if ((reg_addr >= OFS_STATUS) && (reg_addr < OFS_INT_CAUSE)) begin
      off = reg_addr - OFS_STATUS;
      rd_nxt = pick(status, off[1:0]);
    end else if ((reg_addr >= OFS_REMAIN) && (reg_addr < OFS_SPEED_MON)) begin
      off = reg_addr - OFS_REMAIN;
      rd_nxt = pick({4'h0, remain_in}, off[1:0]);
    end else if (reg_addr == OFS_SPEED_MON) begin
      rd_nxt = {3'h0, speed_in[12:8]};
    end else if (reg_addr == OFS_LAST) begin
      rd_nxt = speed_in[7:0];
    end else if (reg_addr == OFS_GPIO) begin
      rd_nxt = {6'h00, lv.gpio1, lv.gpio0};
    end else if (writable && (reg_addr <= OFS_LAST)) begin
      rd_nxt = mem_ff[reg_addr[5:0]];
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      rdata_ff <= rd_nxt;
    end
  end

  assign reg_rdata = rdata_ff;

  ////////////////////////////////////////////////////////////////////
  // assertions
  sequence s_start_pulse_out_cmd_req;
    cmd_wr && (reg_wdata == CMD_START_PULSE_OUT);
  endsequence

  sequence s_start_pulse_out_cmd_low;
    (!ext_start_pin_oe_n) [*8];
  endsequence

  property p_start_pulse_out_cmd;
    @(posedge sys_clk) disable iff (!resetn)
      s_start_pulse_out_cmd_req |=> s_start_pulse_out_cmd_low;
  endproperty
  a_start_pulse_out_cmd: assert property (p_start_pulse_out_cmd) else $error("start one-shot too short");

  property p_start_pulse_out_cmd_end;
    @(posedge sys_clk) disable iff (!resetn)
      s_start_pulse_out_cmd_req ##1 (!(cmd_wr && (reg_wdata == CMD_START_PULSE_OUT))) [*8] |=> ext_start_pin_oe_n;
  endproperty
  a_start_pulse_out_cmd_end: assert property (p_start_pulse_out_cmd_end) else $error("start one-shot too long");

  property p_glitch;
    @(posedge sys_clk) disable iff (!resetn)
      start_evt |-> !$past(lv.start_n, 1) && !$past(lv.start_n, 4);
  endproperty
  a_glitch: assert property (p_glitch) else $error("short start low accepted");

  property p_sync;
    @(posedge sys_clk) disable iff (!resetn)
      (state_ff == ST_ARMED) && !start_evt && !cmd_wr |=> (state_ff != ST_RUN);
  endproperty
  a_sync: assert property (p_sync) else $error("sync start without pin edge");

  property p_block;
    @(posedge sys_clk) disable iff (!resetn)
      cmd_wr && (reg_wdata == CMD_START) && halt_on |=> (state_ff == ST_IDLE) && !motor_run ##1 !motor_run;
  endproperty
  a_block: assert property (p_block) else $error("start taken while stop active");

  property p_halt;
    @(posedge sys_clk) disable iff (!resetn)
      (state_ff == ST_RUN) && halt_on && !cmd_wr |=> (state_ff == (stop_act ? ST_DECEL : ST_IDLE));
  endproperty
  a_halt: assert property (p_halt) else $error("stop action wrong");

  property p_stay;
    @(posedge sys_clk) disable iff (!resetn)
      (state_ff == ST_IDLE) && !cmd_wr |=> (state_ff == ST_IDLE);
  endproperty
  a_stay: assert property (p_stay) else $error("motor restarted without command");

  property p_timer;
    @(posedge sys_clk) disable iff (!resetn)
      timer_mode && !lv.drive_type && !fmt[2] |=> (shared_pin_1 == $past(fmt[0]));
  endproperty
  a_timer: assert property (p_timer) else $error("pulse not masked in timer mode");

  property p_freeze;
    @(posedge sys_clk) disable iff (!resetn)
      timer_mode |=> $stable(phase_idx_ff);
  endproperty
  a_freeze: assert property (p_freeze) else $error("phase moved in timer mode");

  property p_gp;
    @(posedge sys_clk) disable iff (!resetn)
      !lv.drive_type |=> (shared_pin_3 == $past(gpio_ctl[GPIO_GP_LSB + 1]));
  endproperty
  a_gp: assert property (p_gp) else $error("gp output not on pin three");

  property p_byte;
    @(posedge sys_clk) disable iff (!resetn)
      reg_wr && (reg_addr == OFS_ENV1) |=> (mem_ff[9] == $past(mem_ff[9]));
  endproperty
  a_byte: assert property (p_byte) else $error("neighbour byte changed");
endmodule

/* File: core/motor_pin_pkg.sv */
// Purpose: constants and carriers for the motor pin control block
// Assumes: byte-wide register port, one clock, async active-low reset
// Notes: byte 0 of a multi-byte register is its most significant byte
package motor_pin_pkg;
  // register byte offsets
  localparam logic [7:0] OFS_ENV2 = 8'h04;
  localparam logic [7:0] OFS_ENV1 = 8'h08;
  localparam logic [7:0] OFS_DECEL_SC = 8'h0c;
  localparam logic [7:0] OFS_ACCEL_SC = 8'h0e;
  localparam logic [7:0] OFS_DECEL_RATE = 8'h10;
  localparam logic [7:0] OFS_ACCEL_RATE = 8'h12;
  localparam logic [7:0] OFS_SPEED_MUL = 8'h14;
  localparam logic [7:0] OFS_RAMPDOWN = 8'h16;
  localparam logic [7:0] OFS_INIT_SPEED = 8'h19;
  localparam logic [7:0] OFS_SPEED_ONE = 8'h1b;
  localparam logic [7:0] OFS_SPEED_TWO = 8'h1d;
  localparam logic [7:0] OFS_MOVE_CNT = 8'h1f;
  localparam logic [7:0] OFS_OP_MODE = 8'h23;
  localparam logic [7:0] OFS_COMMAND = 8'h25;
  localparam logic [7:0] OFS_STATUS = 8'h26;
  localparam logic [7:0] OFS_INT_CAUSE = 8'h2a;
  localparam logic [7:0] OFS_GPIO = 8'h2c;
  localparam logic [7:0] OFS_POS_CNT = 8'h2e;
  localparam logic [7:0] OFS_REMAIN = 8'h32;
  localparam logic [7:0] OFS_SPEED_MON = 8'h36;
  localparam logic [7:0] OFS_LAST = 8'h37;
  localparam logic [7:0] CFG_RESET = 8'h00;
  // env_config_1 fields (bit positions in the 32-bit word)
  localparam int ENV1_FMT_LSB = 0;
  localparam int ENV1_STOP_POL = 3;
  localparam int ENV1_STOP_ACT = 4;
  localparam int ENV1_CLR_SEL = 5;
  localparam int ENV1_CLR_POL = 6;
  localparam int ENV1_INP_POL = 7;
  // operation_mode fields (16-bit word)
  localparam int MODE_SYNC_EN = 8;
  localparam int MODE_STOP_EN = 9;
  localparam int MODE_INP_WAIT = 10;
  localparam logic [6:0] MODE_TIMER = 7'h40;
  // gpio_control low byte fields
  localparam int GPIO_DIR_LSB = 0;
  localparam int GPIO_OUT_LSB = 2;
  localparam int GPIO_GP_LSB = 4;
  // commands
  localparam logic [7:0] CMD_START = 8'h51;
  localparam logic [7:0] CMD_START_PULSE_OUT = 8'h52;
  localparam logic [7:0] CMD_SPEED_TWO = 8'h53;
  localparam logic [7:0] CMD_HALT_NOW = 8'h49;
  // cycle counts
  localparam logic [2:0] GLITCH_CYCLES = 3'h5;
  localparam logic [3:0] START_PULSE_OUT_CMD_CYCLES = 4'h8;
  localparam logic [3:0] CLEAR_CYCLES = 4'h8;

  typedef struct packed {
    logic start_n;
    logic halt;
    logic inpos_fh;
    logic scheme;
    logic drive_type;
    logic gpio1;
    logic gpio0;
  } pins_s;

  typedef struct packed {
    logic step_tick;
    logic dir_neg;
    logic pulses_done;
    logic decel_done;
  } engine_s;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_ARMED,
    ST_RUN,
    ST_DECEL,
    ST_SETTLE
  } motion_e;
endpackage

/* File: verif/motor_side_model.sv */
// Purpose: switches, start line and driver levels around the pin block
// Assumes: start line is open drain with a pull-up
// Notes: levels are commanded by the bench
module motor_side_model
  import motor_pin_pkg::*;
(
  input wire logic start_out,
  input wire logic start_oe_n,
  input wire logic press,
  input wire logic [3:0] lvl,
  input wire logic [1:0] gp_out,
  input wire logic [1:0] gp_oe_n,
  input wire logic [1:0] gp_ext,
  output pins_s pins
);
  logic line;
  // wired-and start line, pulled high when nobody pulls
  assign line = !press && (start_oe_n || start_out);
  // in-position from the driver, gpio lines resolved by enable
  assign pins = {line, lvl, gp_oe_n[1] ? gp_ext[1] : gp_out[1],
                 gp_oe_n[0] ? gp_ext[0] : gp_out[0]};
endmodule

/* File: verif/test_motor_pulse_pin_control.sv */
// Purpose: register and pin level tests of the pin control block
// Assumes: byte register port, one clock at 250 MHz
// Notes: lvl is {halt, inpos_fh, scheme, drive_type}
module test_motor_pulse_pin_control
  import motor_pin_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk, resetn, reg_wr, reg_rd, press, start_out, start_oe_n;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
  logic [3:0] lvl, p;
  logic [1:0] gp_ext;
  wire [1:0] g_out, g_oe_n;
  logic sp1, sp2, sp3, sp4, clr_pin, motor_run, decel_req, speed_two_sel;
  pins_s pins;
  engine_s eng;
  int miscompares, total_checks, n;
  logic [3:0] tbl [8] = '{4'h8, 4'hc, 4'h4, 4'h6, 4'h2, 4'h3, 4'h1, 4'h9};

  motor_pulse_pin_control i_dut (.sys_clk(sys_clk), .resetn(resetn), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .pins(pins), .eng(eng),
    .remain_in(28'h012_3456), .speed_in(13'h0abc), .ext_start_pin_out(start_out),
    .ext_start_pin_oe_n(start_oe_n), .shared_pin_1(sp1), .shared_pin_2(sp2), .shared_pin_3(sp3),
    .shared_pin_4(sp4), .clear_reduce_pin(clr_pin), .gpio_0_out(g_out[0]), .gpio_0_oe_n(g_oe_n[0]),
    .gpio_1_out(g_out[1]), .gpio_1_oe_n(g_oe_n[1]), .motor_run(motor_run), .decel_req(decel_req),
    .speed_two_sel(speed_two_sel));
  motor_side_model u_side (.start_out(start_out), .start_oe_n(start_oe_n), .press(press), .lvl(lvl),
    .gp_out(g_out), .gp_oe_n(g_oe_n), .gp_ext(gp_ext), .pins(pins));

  initial sys_clk = 0;
  always #2 sys_clk = ~sys_clk;

  ////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    total_checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("FAIL %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    cyc(1);
    reg_wr = 1;
    reg_addr = a;
    reg_wdata = v;
    cyc(1);
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    cyc(1);
    reg_rd = 1;
    reg_addr = a;
    cyc(1);
    reg_rd = 0;
    v = reg_rdata;
  endtask
  task automatic tick(input logic dn);
    eng.dir_neg = dn;
    cyc(1);
    eng.step_tick = 1;
    cyc(1);
    eng.step_tick = 0;
    cyc(3);
  endtask
  // counts cycles with clear pin high, start line driven, or pulse pin high
  task automatic count(input int s, input int k, output int c);
    c = 0;
    repeat (k) begin
      cyc(1);
      case (s)
        0: c += (clr_pin === 1'b1);
        1: c += (start_oe_n === 1'b0);
        default: c += (sp1 === 1'b1);
      endcase
    end
  endtask
  task automatic wait_run(input logic e);
    for (int i = 0; i < 40 && motor_run !== e; i++) cyc(1);
    chk({7'h0, motor_run}, {7'h0, e});
  endtask
  task automatic stop_test();
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  initial begin
    cyc(20000);
    miscompares++;
    stop_test();
  end

  ////////////////////////////////////////////////////////////////
  initial begin
    resetn = 0;
    reg_wr = 0;
    reg_rd = 0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    press = 0;
    lvl = 4'b1110;
    gp_ext = 2'b10;
    eng = '0;
    cyc(5);
    resetn = 1;
    cyc(5);
    // register access, bytewise, reserved and read-only places
    rd(8'h08, d);
    chk(d, 8'h00);
    wr(8'h0b, 8'h60);
    rd(8'h0b, d);
    chk(d, 8'h60);
    rd(8'h0a, d);
    chk(d, 8'h00);
    wr(8'h00, 8'h5a);
    rd(8'h00, d);
    chk(d, 8'h00);
    wr(8'h37, 8'h11);
    rd(8'h37, d);
    chk(d, 8'hbc);
    cyc(3);
    chk({7'h0, clr_pin}, 8'h01);
    wr(8'h0b, 8'h20);
    cyc(3);
    chk({7'h0, clr_pin}, 8'h00);
    rd(8'h29, d);
    chk({4'h0, d[3:0]}, 8'h0b);
    lvl = 4'b0110;
    // gpio directions and general outputs
    wr(8'h2d, 8'h25);
    cyc(6);
    chk({4'h0, g_oe_n, g_out}, 8'h09);
    chk({6'h0, sp3, sp4}, 8'h02);
    rd(8'h2c, d);
    chk({6'h0, d[1:0]}, 8'h03);
    // idle levels of the pulse formats
    for (int f = 0; f < 4; f++) begin
      wr(8'h0b, f[7:0]);
      cyc(3);
      chk({6'h0, sp1, sp2}, {6'h0, f[0], f[1]});
    end
    wr(8'h0b, 8'h00);
    wr(OFS_COMMAND, CMD_START);
    wait_run(1'b1);
    eng.dir_neg = 1;
    eng.step_tick = 1;
    count(2, 1, n);
    eng.step_tick = 0;
    chk(n[7:0], 8'h01);
    count(2, 6, n);
    chk(n[7:0], 8'h00);
    wr(8'h24, 8'h40);
    eng.step_tick = 1;
    count(2, 6, n);
    eng.step_tick = 0;
    chk(n[7:0], 8'h00);
    chk({7'h0, sp2}, 8'h01);
    eng.dir_neg = 0;
    wr(8'h24, 8'h00);
    // immediate halt with clear pulse, latched stop, blocked start
    wr(8'h0b, 8'h48);
    wr(8'h23, 8'h02);
    lvl[3] = 1;
    count(0, 30, n);
    chk(n[7:0], {4'h0, CLEAR_CYCLES});
    chk({7'h0, motor_run}, 8'h00);
    lvl[3] = 0;
    cyc(10);
    chk({7'h0, motor_run}, 8'h00);
    lvl[3] = 1;
    wr(OFS_COMMAND, CMD_START);
    cyc(8);
    chk({7'h0, motor_run}, 8'h00);
    lvl[3] = 0;
    cyc(6);
    // decelerating halt
    wr(8'h0b, 8'h18);
    wr(OFS_COMMAND, CMD_START);
    wait_run(1'b1);
    lvl[3] = 1;
    cyc(8);
    chk({6'h0, decel_req, motor_run}, 8'h03);
    eng.decel_done = 1;
    cyc(1);
    eng.decel_done = 0;
    wait_run(1'b0);
    lvl[3] = 0;
    // synchronous start from the start line
    wr(8'h23, 8'h01);
    wr(OFS_COMMAND, CMD_START);
    cyc(10);
    chk({7'h0, motor_run}, 8'h00);
    press = 1;
    cyc(3);
    press = 0;
    cyc(12);
    chk({7'h0, motor_run}, 8'h00);
    press = 1;
    cyc(12);
    press = 0;
    wait_run(1'b1);
    wr(OFS_COMMAND, CMD_HALT_NOW);
    wait_run(1'b0);
    // in-position wait after the last pulse
    wr(8'h23, 8'h04);
    wr(OFS_COMMAND, CMD_START);
    wait_run(1'b1);
    eng.pulses_done = 1;
    cyc(1);
    eng.pulses_done = 0;
    wait_run(1'b0);
    rd(8'h28, d);
    chk({7'h0, d[2]}, 8'h01);
    lvl[2] = 0;
    cyc(8);
    rd(8'h28, d);
    chk({7'h0, d[2]}, 8'h00);
    wr(8'h23, 8'h00);
    // host loads speed two, then switches
    wr(8'h1d, 8'h01);
    wr(8'h1e, 8'h23);
    wr(OFS_COMMAND, CMD_SPEED_TWO);
    cyc(2);
    chk({7'h0, speed_two_sel}, 8'h01);
    // start pulse out
    wr(OFS_COMMAND, CMD_START_PULSE_OUT);
    chk({7'h0, start_oe_n}, 8'h00);
    count(1, 16, n);
    chk(n[7:0] + 8'h01, {4'h0, START_PULSE_OUT_CMD_CYCLES});
    wr(OFS_COMMAND, CMD_START_PULSE_OUT);
    cyc(5);
    rd(8'h29, d);
    chk({7'h0, d[0]}, 8'h00);
    cyc(12);
    // excitation phases, 1-2 and 2-2 unipolar, then bipolar
    lvl = 4'b0101;
    cyc(6);
    wr(OFS_COMMAND, CMD_START);
    wait_run(1'b1);
    p = {sp1, sp2, sp3, sp4};
    rd(8'h29, d);
    chk({5'h0, d[7:5]}, {5'h0, p[2:0]});
    for (int i = 0; i < 8; i++) if (tbl[i] === p) n = i;
    tick(1'b0);
    chk({4'h0, sp1, sp2, sp3, sp4}, {4'h0, tbl[(n + 1) % 8]});
    tick(1'b1);
    chk({4'h0, sp1, sp2, sp3, sp4}, {4'h0, p});
    wr(8'h24, 8'h40);
    tick(1'b0);
    chk({4'h0, sp1, sp2, sp3, sp4}, {4'h0, p});
    wr(8'h24, 8'h00);
    lvl = 4'b0001;
    cyc(6);
    tick(1'b0);
    chk(8'($countones({sp1, sp2, sp3, sp4})), 8'h02);
    lvl = 4'b0011;
    cyc(6);
    chk({6'h0, sp3, sp4}, 8'h03);
    wr(OFS_COMMAND, CMD_HALT_NOW);
    wait_run(1'b0);
    stop_test();
  end
endmodule
